//--- include/msc_pkg.sv
// constants and types for the mac security control register bank
package msc_pkg;
  // host serial frame layout
  localparam int HDR_BITS = 16;
  localparam int ADDR_W = 11;
  localparam int HDR_WR_BIT = 15;
  // buffer and fifo geometry
  localparam int BUF_DEPTH = 256;
  localparam int RX_FIFO_DEPTH = 32;
  localparam int BYTE_W = 8;
  localparam int SEC_BYTES = 92;
  localparam int NONCE_BYTES = 13;
  localparam int BLOCK_W = 128;
  // register offsets
  localparam logic [10:0] A_RX_WPTR = 11'h081;
  localparam logic [10:0] A_KEY_A = 11'h100;
  localparam logic [10:0] A_RX_NONCE = 11'h110;
  localparam logic [10:0] A_SA_BUF = 11'h120;
  localparam logic [10:0] A_KEY_B = 11'h130;
  localparam logic [10:0] A_TX_NONCE = 11'h140;
  localparam logic [10:0] A_EXT_ADDR = 11'h150;
  localparam logic [10:0] A_NET_ID = 11'h158;
  localparam logic [10:0] A_SHORT_ADDR = 11'h15A;
  localparam logic [10:0] A_SEC_END = 11'h15B;
  localparam logic [10:0] A_STATUS = 11'h180;
  localparam logic [10:0] A_TRIG = 11'h18E;
  localparam logic [10:0] A_RESETS = 11'h190;
  localparam logic [10:0] A_RX_CTRL = 11'h191;
  localparam logic [10:0] A_ACK_SEQ = 11'h192;
  localparam logic [10:0] A_SEC_SETUP = 11'h193;
  localparam logic [10:0] A_TX_HLEN = 11'h194;
  localparam logic [10:0] A_RX_HLEN = 11'h195;
  localparam logic [10:0] A_BANK = 11'h19F;
  localparam logic [10:0] A_SEND_LO = 11'h300;
  localparam logic [10:0] A_SEND_HI = 11'h3FF;
  localparam logic [10:0] A_RECV_LO = 11'h400;
  localparam logic [10:0] A_RECV_HI = 11'h4FF;
  // status bit positions
  localparam int ST_CIPHER = 7;
  localparam int ST_TX_BUSY = 6;
  localparam int ST_RX_BUSY = 5;
  localparam int ST_SA_DONE = 4;
  localparam int ST_DECODE = 3;
  localparam int ST_ENCRYPTION_FINISHED = 2;
  localparam int ST_DECRYPTION_FINISHED = 1;
  localparam int ST_CRC = 0;
  // reset strobe bit positions
  localparam int RS_BUF = 7;
  localparam int RS_SEND_FSM = 6;
  localparam int RS_RECV_FSM = 5;
  localparam int RS_CIPHER = 4;
  // receive control bit positions
  localparam int RC_ACK_SEQ = 4;
  localparam int RC_COORD = 3;
  localparam int RC_ADDR = 2;
  localparam int RC_CRC = 1;
  localparam int RC_AUTO_ACK = 0;
  // security setup bit positions
  localparam int SS_SA_KEY = 7;
  localparam int SS_TX_KEY = 6;
  localparam int SS_RX_KEY = 5;
  localparam int SS_AUTH_LSB = 2;
  localparam int SS_MODE_LSB = 0;
  // reset values
  localparam logic [4:0] RX_CTRL_RST = 5'h06;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] PINS_RST = 3'h4;
  // field masks for partly reserved registers
  localparam logic [7:0] STATUS_WR_MASK = 8'h17;
  localparam logic [7:0] HLEN_MASK = 8'h7F;
  // security modes
  typedef enum logic [1:0] {
    MSC_MODE_NONE = 2'h0,
    MSC_MODE_AUTH = 2'h1,
    MSC_MODE_CTR = 2'h2,
    MSC_MODE_BOTH = 2'h3
  } msc_mode_t;
  // host serial states, gray along idle, header, data
  typedef enum logic [1:0] {
    MSC_SP_IDLE = 2'b00,
    MSC_SP_HDR = 2'b01,
    MSC_SP_DATA = 2'b11
  } msc_spi_t;
endpackage : msc_pkg

//--- src/msc_top.sv
// mac security control register bank with host serial slave and receive fifo
// Contract
// - separate send and receive buffers, 256 bytes each
// - bank select bit 0 shows mac view, 1 shows security view
// - 0x300-0x3FF send buffer, 0x400-0x4FF receive buffer, bank picks which
// - auto acknowledge sends ack for correctly received frames; resets to 0
// - two 128-bit keys at 0x100 and 0x130, top address most significant
// - decryption nonce: sequence 0x110, counter msb 0x114, source msb 0x11C
// - encryption nonce: sequence 0x140, counter msb 0x144, source msb 0x14C
// - standalone buffer feeds cipher and takes its result; msb at 0x12F
// - extended, network and short addresses stored msb at higher address
// - status bits 7,6,5 show cipher, send and receive activity
// - status bits 4,2,1 set on cipher completions; host writable; reset 0
// - status bit 3 on validity check pass, bit 0 on checksum pass
// - trigger write starts standalone cipher with picked key; self clears
// - reset register bits 7..4 init buffers, send fsm, receive fsm, cipher
// - sequence check drops receive interrupt for mismatched ack sequence
// - address filter, reset 1, drops interrupt for foreign addresses
// - checksum filter, reset 1, drops interrupt for bad checksum
// - key pick bits 7,6,5 for standalone, send, receive; 0 first key
// - auth length code 1..7 means 4..16 bytes in steps of two
// - cipher mode: none, auth chaining, counter, combined
// - 7-bit send and receive header lengths, meaning set by mode
// - low mac control registers only reachable while bank select is 0
`timescale 1ns/10ps

module msc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input logic clock,
  input logic rst_n,
  input logic flush,
  // fill side
  input logic in_valid,
  input logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic not_full_q;
  wire push = in_valid & not_full_q;
  wire pop = out_valid & out_ready;

  assign in_ready = not_full_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign cnt_d = flush ? '0 : cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n || flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      not_full_q <= 1'b1;
    end
    else
    begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_d;
      not_full_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule : msc_fifo

module msc_top (
  // clock and reset
  input logic clock,
  input logic rst_n,
  // host serial pins
  input logic spi_cs_n,
  input logic spi_sclk,
  input logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // modem receive byte stream
  input logic rx_byte_valid,
  input logic [msc_pkg::BYTE_W-1:0] rx_byte,
  output logic rx_byte_ready,
  // received frame report
  input logic rx_frame_done,
  input logic rx_frame_crc_ok,
  input logic rx_frame_decode_ok,
  input logic rx_frame_addr_match,
  input logic rx_frame_is_ack,
  input logic rx_frame_ack_wanted,
  input logic [7:0] rx_frame_seq,
  output logic rx_irq,
  output logic ack_send,
  // modem send buffer read
  input logic [7:0] tx_rd_addr,
  output logic [7:0] tx_rd_data,
  // activity and completion from engines
  input logic tx_busy,
  input logic rx_busy,
  input logic enc_active,
  input logic encryption_finished,
  input logic decryption_finished,
  // standalone cipher core
  output logic aes_start,
  output logic [msc_pkg::BLOCK_W-1:0] aes_key,
  output logic [msc_pkg::BLOCK_W-1:0] aes_block,
  input logic aes_done,
  input logic [msc_pkg::BLOCK_W-1:0] aes_result,
  // stored keys, nonces and addresses
  output logic [127:0] cipher_key_a,
  output logic [127:0] cipher_key_b,
  output logic [103:0] receive_nonce_bytes,
  output logic [103:0] transmit_nonce_bytes,
  output logic [63:0] extended_device_address,
  output logic [15:0] network_identifier,
  output logic [15:0] short_network_address,
  // configuration
  output logic [1:0] cipher_mode,
  output logic [4:0] auth_length_bytes,
  output logic [6:0] transmit_header_length,
  output logic [6:0] receive_header_length,
  output logic send_key_pick,
  output logic receive_key_pick,
  output logic coordinator_role_enable,
  output logic bank_select_bit,
  // init strobes
  output logic buffer_init_strobe,
  output logic send_fsm_init_strobe,
  output logic receive_fsm_init_strobe,
  output logic cipher_init_strobe
);
  import msc_pkg::*;

  function automatic logic in_range(input logic [10:0] a, input logic [10:0] lo,
                                    input logic [10:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // security byte window without the gaps behind the two nonces
  function automatic logic sec_hit(input logic [10:0] a);
    sec_hit = in_range(a, A_KEY_A, A_SEC_END) &&
              !in_range(a, A_RX_NONCE + 11'(NONCE_BYTES), A_SA_BUF - 11'd1) &&
              !in_range(a, A_TX_NONCE + 11'(NONCE_BYTES), A_EXT_ADDR - 11'd1);
  endfunction : sec_hit

  function automatic logic [2:0] agree(input logic [2:0] s2, input logic [2:0] s3,
                                       input logic [2:0] held);
    agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
  endfunction : agree

  // buffers
  logic [7:0] mac_send_buffer [0:BUF_DEPTH-1];
  logic [7:0] secure_send_buffer [0:BUF_DEPTH-1];
  logic [7:0] mac_receive_buffer [0:BUF_DEPTH-1];
  logic [7:0] secure_receive_buffer [0:BUF_DEPTH-1];

  // register state
  logic [SEC_BYTES*8-1:0] sec_q;
  logic sa_done_q, encryption_finished_q, decryption_finished_q, crc_q, decode_q, sa_busy_q;
  logic [3:0] strobe_q;
  logic [4:0] rx_ctrl_q;
  logic [7:0] ack_seq_q;
  logic [7:0] setup_q;
  logic [6:0] tx_hlen_q, rx_hlen_q;
  logic [4:0] auth_len_q;
  logic bank_q;
  logic [7:0] rx_wp_q;

  // host serial state
  logic [2:0] sy1_q, sy2_q, sy3_q, pin_q;
  msc_spi_t spi_st_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] shin_q;
  logic [10:0] addr_q;
  logic wr_q;
  logic [7:0] shout_q;
  logic miso_q, miso_oe_q;

  // output flops
  logic rx_irq_q, ack_send_q, aes_start_q;
  logic [7:0] tx_rd_data_q;
  logic [BLOCK_W-1:0] aes_key_q, aes_block_q;

  // pin filter and edges
  wire [2:0] pin_d = agree(sy2_q, sy3_q, pin_q);
  wire cs_act = ~pin_d[2];
  wire rise = pin_d[1] & ~pin_q[1] & cs_act & (spi_st_q != MSC_SP_IDLE);
  wire mosi_s = pin_d[0];
  wire [15:0] hdr_word = {shin_q[14:0], mosi_s};
  wire hdr_end = rise && (spi_st_q == MSC_SP_HDR) && (bit_cnt_q == 4'd15);
  wire byte_end = rise && (spi_st_q == MSC_SP_DATA) && (bit_cnt_q == 4'd7);
  wire [10:0] rd_addr = (spi_st_q == MSC_SP_HDR) ? hdr_word[10:0] : addr_q + 11'd1;

  // host write decode
  wire wr_stb = byte_end & wr_q;
  wire [7:0] wdata = {shin_q[6:0], mosi_s};
  wire [2:0] auth_code = wdata[SS_AUTH_LSB +: 3];
  // code 0 gives no field, 1..7 gives 2*code+2 bytes
  wire [4:0] auth_len_d = (auth_code == 3'd0) ? 5'd0 : {1'b0, auth_code, 1'b0} + 5'd2;
  wire wr_sec = wr_stb & sec_hit(addr_q);
  wire [6:0] wr_idx = 7'(addr_q - A_KEY_A);
  wire wr_send = wr_stb & in_range(addr_q, A_SEND_LO, A_SEND_HI);
  wire wr_recv = wr_stb & in_range(addr_q, A_RECV_LO, A_RECV_HI);
  wire wr_mac_recv = wr_recv & ~bank_q;
  wire wr_status = wr_stb & (addr_q == A_STATUS);
  wire wr_resets = wr_stb & (addr_q == A_RESETS);
  wire trig = wr_stb & (addr_q == A_TRIG) & wdata[0] & ~sa_busy_q;
  wire sa_fin = sa_busy_q & aes_done;

  // host read decode
  wire [6:0] rd_idx = 7'(rd_addr - A_KEY_A);
  wire [7:0] rd_buf = rd_addr[7:0];
  wire [7:0] status_w = {sa_busy_q | enc_active, tx_busy, rx_busy, sa_done_q,
                         decode_q, encryption_finished_q, decryption_finished_q, crc_q};
  wire [7:0] send_rd = bank_q ? secure_send_buffer[rd_buf] : mac_send_buffer[rd_buf];
  wire [7:0] recv_rd = bank_q ? secure_receive_buffer[rd_buf]
                              : mac_receive_buffer[rd_buf];
  wire [7:0] rd_byte =
    (rd_addr == A_RX_WPTR) ? (bank_q ? BYTE_RST : rx_wp_q) :
    sec_hit(rd_addr) ? sec_q[{rd_idx, 3'b000} +: 8] :
    (rd_addr == A_STATUS) ? status_w :
    (rd_addr == A_RX_CTRL) ? {3'b000, rx_ctrl_q} :
    (rd_addr == A_ACK_SEQ) ? ack_seq_q :
    (rd_addr == A_SEC_SETUP) ? setup_q :
    (rd_addr == A_TX_HLEN) ? {1'b0, tx_hlen_q} :
    (rd_addr == A_RX_HLEN) ? {1'b0, rx_hlen_q} :
    (rd_addr == A_BANK) ? {7'b000_0000, bank_q} :
    in_range(rd_addr, A_SEND_LO, A_SEND_HI) ? send_rd :
    in_range(rd_addr, A_RECV_LO, A_RECV_HI) ? recv_rd : BYTE_RST;

  // receive path: modem fifo drains into the mac receive buffer
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  wire drain_ok = ~wr_mac_recv & ~strobe_q[3];
  wire drain = fifo_out_valid & drain_ok;

  msc_fifo #(.WIDTH(BYTE_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(strobe_q[3]),
    .in_valid(rx_byte_valid),
    .in_data(rx_byte),
    .in_ready(rx_byte_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(drain_ok)
  );

  // receive filtering
  wire drop_seq = rx_ctrl_q[RC_ACK_SEQ] & rx_frame_is_ack & (rx_frame_seq != ack_seq_q);
  wire drop_adr = rx_ctrl_q[RC_ADDR] & ~rx_frame_addr_match;
  wire drop_crc = rx_ctrl_q[RC_CRC] & ~rx_frame_crc_ok;
  wire ack_due = rx_ctrl_q[RC_AUTO_ACK] & rx_frame_crc_ok & rx_frame_addr_match &
                 rx_frame_ack_wanted & ~rx_frame_is_ack;

  // status flag next values, hardware set wins over host write
  wire sa_done_d = sa_fin | (wr_status ? wdata[ST_SA_DONE] : sa_done_q);
  wire encryption_finished_d = encryption_finished | (wr_status ? wdata[ST_ENCRYPTION_FINISHED] : encryption_finished_q);
  wire decryption_finished_d = decryption_finished | (wr_status ? wdata[ST_DECRYPTION_FINISHED] : decryption_finished_q);
  wire crc_d = rx_frame_done ? rx_frame_crc_ok : (wr_status ? wdata[ST_CRC] : crc_q);
  wire decode_d = rx_frame_done ? rx_frame_decode_ok : decode_q;

  // pin synchroniser
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sy1_q <= PINS_RST;
      sy2_q <= PINS_RST;
      sy3_q <= PINS_RST;
      pin_q <= PINS_RST;
    end
    else
    begin
      sy1_q <= {spi_cs_n, spi_sclk, spi_mosi};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin_q <= pin_d;
    end
  end

  // host serial frame: 16-bit header then bytes, address steps per byte
  always_ff @(posedge clock)
  begin
    if (!rst_n || !cs_act)
    begin
      spi_st_q <= MSC_SP_IDLE;
      bit_cnt_q <= 4'd0;
      shin_q <= 16'h0000;
      addr_q <= 11'h000;
      wr_q <= 1'b0;
      shout_q <= BYTE_RST;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end
    else
    begin
      miso_oe_q <= 1'b1;
      case (spi_st_q)
        MSC_SP_IDLE:
        begin
          spi_st_q <= MSC_SP_HDR;
        end
        MSC_SP_HDR, MSC_SP_DATA:
        begin
          if (rise)
          begin
            shin_q <= hdr_word;
            bit_cnt_q <= (hdr_end || byte_end) ? 4'd0 : bit_cnt_q + 4'd1;
            if (hdr_end || byte_end)
            begin
              spi_st_q <= MSC_SP_DATA;
              addr_q <= rd_addr;
              shout_q <= rd_byte;
              miso_q <= rd_byte[7];
            end
            else
            begin
              shout_q <= {shout_q[6:0], 1'b0};
              miso_q <= shout_q[6];
            end
            if (hdr_end)
            begin
              wr_q <= hdr_word[HDR_WR_BIT];
            end
          end
        end
        default:
        begin
          spi_st_q <= MSC_SP_IDLE;
        end
      endcase
    end
  end

  // buffer memories
  always_ff @(posedge clock)
  begin
    if (wr_send && !bank_q)
    begin
      mac_send_buffer[addr_q[7:0]] <= wdata;
    end
    if (wr_send && bank_q)
    begin
      secure_send_buffer[addr_q[7:0]] <= wdata;
    end
    if (wr_mac_recv)
    begin
      mac_receive_buffer[addr_q[7:0]] <= wdata;
    end
    else if (drain)
    begin
      mac_receive_buffer[rx_wp_q] <= fifo_out_data;
    end
    if (wr_recv && bank_q)
    begin
      secure_receive_buffer[addr_q[7:0]] <= wdata;
    end
    tx_rd_data_q <= mac_send_buffer[tx_rd_addr];
  end

  // key, nonce, standalone buffer and address bytes
  always_ff @(posedge clock)
  begin
    if (wr_sec)
    begin
      sec_q[{wr_idx, 3'b000} +: 8] <= wdata;
    end
    if (sa_fin)
    begin
      sec_q[(A_SA_BUF - A_KEY_A)*8 +: BLOCK_W] <= aes_result;
    end
  end

  // status, control and configuration registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sa_done_q <= 1'b0;
      encryption_finished_q <= 1'b0;
      decryption_finished_q <= 1'b0;
      crc_q <= 1'b0;
      decode_q <= 1'b0;
      strobe_q <= 4'h0;
      rx_ctrl_q <= RX_CTRL_RST;
      ack_seq_q <= BYTE_RST;
      setup_q <= BYTE_RST;
      auth_len_q <= 5'h00;
      tx_hlen_q <= 7'h00;
      rx_hlen_q <= 7'h00;
      bank_q <= 1'b0;
      rx_wp_q <= BYTE_RST;
      rx_irq_q <= 1'b0;
      ack_send_q <= 1'b0;
    end
    else
    begin
      sa_done_q <= sa_done_d;
      encryption_finished_q <= encryption_finished_d;
      decryption_finished_q <= decryption_finished_d;
      crc_q <= crc_d;
      decode_q <= decode_d;
      strobe_q <= wr_resets ? wdata[RS_BUF:RS_CIPHER] : 4'h0;
      rx_irq_q <= rx_frame_done & ~(drop_seq | drop_adr | drop_crc);
      ack_send_q <= rx_frame_done & ack_due;
      if (strobe_q[3])
      begin
        rx_wp_q <= BYTE_RST;
      end
      else if (drain)
      begin
        rx_wp_q <= rx_wp_q + 8'd1;
      end
      if (wr_stb && addr_q == A_RX_CTRL)
      begin
        rx_ctrl_q <= wdata[4:0];
      end
      if (wr_stb && addr_q == A_ACK_SEQ)
      begin
        ack_seq_q <= wdata;
      end
      if (wr_stb && addr_q == A_SEC_SETUP)
      begin
        setup_q <= wdata;
        auth_len_q <= auth_len_d;
      end
      if (wr_stb && addr_q == A_TX_HLEN)
      begin
        tx_hlen_q <= wdata[6:0];
      end
      if (wr_stb && addr_q == A_RX_HLEN)
      begin
        rx_hlen_q <= wdata[6:0];
      end
      if (wr_stb && addr_q == A_BANK)
      begin
        bank_q <= wdata[0];
      end
    end
  end

  // standalone cipher sequencing
  always_ff @(posedge clock)
  begin
    if (!rst_n || strobe_q[0])
    begin
      sa_busy_q <= 1'b0;
      aes_start_q <= 1'b0;
      aes_key_q <= '0;
      aes_block_q <= '0;
    end
    else
    begin
      aes_start_q <= trig;
      if (trig)
      begin
        sa_busy_q <= 1'b1;
        aes_key_q <= setup_q[SS_SA_KEY] ? cipher_key_b : cipher_key_a;
        aes_block_q <= sec_q[(A_SA_BUF - A_KEY_A)*8 +: BLOCK_W];
      end
      else if (sa_fin)
      begin
        sa_busy_q <= 1'b0;
      end
    end
  end

  // outputs
  assign spi_miso = miso_q;
  assign spi_miso_oe = miso_oe_q;
  assign rx_irq = rx_irq_q;
  assign ack_send = ack_send_q;
  assign tx_rd_data = tx_rd_data_q;
  assign aes_start = aes_start_q;
  assign aes_key = aes_key_q;
  assign aes_block = aes_block_q;
  assign cipher_key_a = sec_q[(A_KEY_A - A_KEY_A)*8 +: 128];
  assign cipher_key_b = sec_q[(A_KEY_B - A_KEY_A)*8 +: 128];
  assign receive_nonce_bytes = sec_q[(A_RX_NONCE - A_KEY_A)*8 +: 104];
  assign transmit_nonce_bytes = sec_q[(A_TX_NONCE - A_KEY_A)*8 +: 104];
  assign extended_device_address = sec_q[(A_EXT_ADDR - A_KEY_A)*8 +: 64];
  assign network_identifier = sec_q[(A_NET_ID - A_KEY_A)*8 +: 16];
  assign short_network_address = sec_q[(A_SHORT_ADDR - A_KEY_A)*8 +: 16];
  assign cipher_mode = setup_q[SS_MODE_LSB +: 2];
  assign auth_length_bytes = auth_len_q;
  assign transmit_header_length = tx_hlen_q;
  assign receive_header_length = rx_hlen_q;
  assign send_key_pick = setup_q[SS_TX_KEY];
  assign receive_key_pick = setup_q[SS_RX_KEY];
  assign coordinator_role_enable = rx_ctrl_q[RC_COORD];
  assign bank_select_bit = bank_q;
  assign buffer_init_strobe = strobe_q[3];
  assign send_fsm_init_strobe = strobe_q[2];
  assign receive_fsm_init_strobe = strobe_q[1];
  assign cipher_init_strobe = strobe_q[0];
endmodule : msc_top

//--- bench/msc_monitor.sv
// assertion checker on the mac security control top ports
`timescale 1ns/10ps
module msc_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // frame report
  input wire logic rx_frame_done,
  input wire logic rx_frame_crc_ok,
  input wire logic rx_frame_addr_match,
  input wire logic rx_frame_is_ack,
  input wire logic rx_frame_ack_wanted,
  input wire logic rx_irq,
  input wire logic ack_send,
  // control outputs
  input wire logic aes_start,
  input wire logic send_fsm_init_strobe,
  input wire logic bank_select_bit
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_irq_pass: assert property (rx_frame_done && rx_frame_crc_ok && rx_frame_addr_match
    && !rx_frame_is_ack |=> rx_irq) else $error("receive irq missing");
  a_irq_cause: assert property (!rx_frame_done |=> !rx_irq) else $error("stray irq");
  a_ack_cause: assert property (!(rx_frame_done && rx_frame_crc_ok
    && rx_frame_ack_wanted) |=> !ack_send) else $error("stray ack");
  a_ack_irq: assert property (ack_send |-> rx_irq) else $error("ack without irq");
  a_ack_frame: assert property (rx_frame_is_ack |=> !ack_send) else $error("ack to ack");
  a_start_pulse: assert property (aes_start |=> !aes_start) else $error("start held");
  a_strobe_pulse: assert property (send_fsm_init_strobe
    |=> !send_fsm_init_strobe) else $error("strobe held");
  a_bank_reset: assert property ($rose(rst_n) |-> !bank_select_bit) else $error("bank");
  c_irq: cover property (rx_irq);
  c_ack: cover property (ack_send);
  c_start: cover property (aes_start);
endmodule : msc_monitor
bind msc_top msc_monitor msc_monitor_inst (.clock(clock), .rst_n(rst_n),
  .rx_frame_done(rx_frame_done), .rx_frame_crc_ok(rx_frame_crc_ok),
  .rx_frame_addr_match(rx_frame_addr_match), .rx_frame_is_ack(rx_frame_is_ack),
  .rx_frame_ack_wanted(rx_frame_ack_wanted), .rx_irq(rx_irq), .ack_send(ack_send),
  .aes_start(aes_start), .send_fsm_init_strobe(send_fsm_init_strobe),
  .bank_select_bit(bank_select_bit));

//--- bench/msc_host_model.sv
// host serial master model, mode 0, msb first
`timescale 1ns/10ps
module msc_host_model (
  // clock
  input wire logic clock,
  // host serial pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial {spi_cs_n, spi_sclk, spi_mosi} = 3'h4;
  // one header and one byte per frame
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [23:0] f;
    f = {w, 4'h0, a, d};
    spi_cs_n = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 23; i >= 0; i--)
    begin
      spi_mosi = f[i];
      repeat (4) @(negedge clock);
      spi_sclk = 1'b1;
      q = {q[6:0], spi_miso};
      repeat (4) @(negedge clock);
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge clock);
    spi_cs_n = 1'b1;
    spi_mosi = !spi_mosi;
    repeat (8) @(negedge clock);
  endtask : xfer
endmodule : msc_host_model

//--- bench/msc_top_test.sv
// self-checking bench for the mac security control register bank
`timescale 1ns/10ps
module msc_top_test;
  import msc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, rx_byte_ready, rx_irq, ack_send, aes_start;
  logic bank_select_bit, fd_q;
  logic rx_byte_valid = 1'b0;
  logic aes_done = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] tx_rd_addr = 8'hFF;
  logic [13:0] fr = 14'h0000;
  logic [4:0] eng = 5'h00;
  logic [127:0] aes_res = 128'h0000;
  logic [127:0] aes_key, aes_block, kb, blk;
  logic [1:0] cipher_mode, kp;
  logic [6:0] hl;
  logic [4:0] auth_len;
  logic [3:0] strb;
  logic [7:0] q, d, b0, tx_rd_data;
  logic [13:0] lf;
  logic [7:0] exp_q [$];
  logic [1:0] fq [$];
  int mismatches = 0;
  int total_checks = 0;
  int strobes = 0;
  int starts = 0;
  int n = 0;
  event got;
  msc_top msc_top_inst (.clock(clock), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_byte_ready(rx_byte_ready),
    .rx_frame_done(fr[13]), .rx_frame_crc_ok(fr[12]), .rx_frame_decode_ok(fr[11]),
    .rx_frame_addr_match(fr[10]), .rx_frame_is_ack(fr[9]), .rx_frame_ack_wanted(fr[8]),
    .rx_frame_seq(fr[7:0]), .rx_irq(rx_irq), .ack_send(ack_send),
    .tx_rd_addr(tx_rd_addr), .tx_rd_data(tx_rd_data), .tx_busy(eng[4]), .rx_busy(eng[3]),
    .enc_active(eng[2]), .encryption_finished(eng[1]), .decryption_finished(eng[0]), .aes_start(aes_start),
    .aes_key(aes_key), .aes_block(aes_block), .aes_done(aes_done), .aes_result(aes_res),
    .cipher_key_a(), .cipher_key_b(), .receive_nonce_bytes(), .transmit_nonce_bytes(),
    .extended_device_address(), .network_identifier(), .short_network_address(),
    .cipher_mode(cipher_mode), .auth_length_bytes(auth_len), .transmit_header_length(hl),
    .receive_header_length(), .send_key_pick(kp[1]), .receive_key_pick(kp[0]),
    .coordinator_role_enable(), .bank_select_bit(bank_select_bit),
    .buffer_init_strobe(strb[3]), .send_fsm_init_strobe(strb[2]),
    .receive_fsm_init_strobe(strb[1]), .cipher_init_strobe(strb[0]));
  msc_host_model msc_host_model_inst (.clock(clock), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  always #50 clock = !clock;
  always @(posedge clock)
  begin
    fd_q <= fr[13];
    starts <= starts + int'(aes_start);
    strobes <= strobes + $countones(strb);
  end
  always @(negedge clock)
    if (fd_q === 1'b1)
      check({rx_irq, ack_send}, fq.pop_front());
  always @(got)
    check(q, exp_q.pop_front());
  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    total_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    msc_host_model_inst.xfer(1'b1, a, v, q);
  endtask : wr
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    msc_host_model_inst.xfer(1'b0, a, 8'h00, q);
    -> got;
  endtask : rd
  // m set: sequence check and auto ack on, filters off
  task automatic frame(input logic m);
    lf = {1'b1, 13'($urandom)};
    if (m && lf[0])
      lf[7:0] = 8'h3C;
    fq.push_back({m ? !(lf[9] && lf[7:0] != 8'h3C) : lf[12] && lf[10],
      m && lf[12] && lf[10] && lf[8] && !lf[9]});
    fr = lf;
    @(negedge clock);
    fr[13] = 1'b0;
    @(negedge clock);
  endtask : frame
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (60000) @(posedge clock);
    mismatches++;
    stop_test;
  end
  initial
  begin
    void'($urandom(32'hedec));
    repeat (13) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    rd(A_RX_CTRL, 8'h06);
    rd(A_BANK, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      d = {3'($urandom), 3'(c), 2'(c)};
      wr(A_SEC_SETUP, d);
      check(auth_len, c ? 2 * c + 2 : 0);
      check(cipher_mode, d[1:0]);
      check(kp, d[6:5]);
      rd(A_SEC_SETUP, d);
    end
    wr(A_TX_HLEN, 8'hFF);
    check(hl, 7'h7F);
    rd(A_TX_HLEN, 8'h7F);
    for (int i = 32; i < 64; i++)
    begin
      d = 8'($urandom);
      wr(A_KEY_A + 11'(i), d);
      if (i < 48) blk[8*(i-32)+:8] = d;
      if (i >= 48) kb[8*(i-48)+:8] = d;
    end
    wr(11'h11E, 8'hFF);
    rd(11'h11E, 8'h00);
    wr(A_SEC_SETUP, 8'h80);
    wr(A_TRIG, 8'h01);
    check(starts, 1);
    check(aes_key, kb);
    check(aes_block, blk);
    aes_res = {$urandom, $urandom, $urandom, $urandom};
    aes_done = 1'b1;
    @(negedge clock);
    aes_done = 1'b0;
    rd(A_SA_BUF + 11'h00F, aes_res[127:120]);
    rd(A_TRIG, 8'h00);
    for (int i = 0; i < 12; i++) frame(1'b0);
    wr(A_RX_CTRL, 8'h11);
    wr(A_ACK_SEQ, 8'h3C);
    for (int i = 0; i < 12; i++) frame(1'b1);
    eng = 5'h1F;
    @(negedge clock);
    eng = 5'h1C;
    rd(A_STATUS, {4'hF, lf[11], 2'h3, lf[12]});
    eng = 5'h00;
    wr(A_STATUS, 8'h00);
    rd(A_STATUS, {4'h0, lf[11], 3'h0});
    wr(A_BANK, 8'hFF);
    check(bank_select_bit, 1'b1);
    rd(A_BANK, 8'h01);
    wr(A_SEND_HI, 8'hA5);
    wr(A_BANK, 8'h00);
    wr(A_SEND_HI, 8'h5A);
    check(tx_rd_data, 8'h5A);
    wr(A_BANK, 8'h01);
    rd(A_SEND_HI, 8'hA5);
    wr(A_BANK, 8'h00);
    wr(A_RESETS, 8'hFF);
    check(strobes, 4);
    rd(A_RESETS, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      rx_byte = 8'($urandom);
      rx_byte_valid = 1'b1;
      if (n == 0 && rx_byte_ready) b0 = rx_byte;
      n += int'(rx_byte_ready);
      @(negedge clock);
    end
    rx_byte_valid = 1'b0;
    rd(A_RX_WPTR, 8'(n));
    rd(A_RECV_LO, b0);
    wr(A_BANK, 8'h01);
    rd(A_RX_WPTR, 8'h00);
    stop_test;
  end
endmodule : msc_top_test
